// File: common/ivs_map.svh
// Purpose: Register offsets, field positions and reset values of the vector/shadow block
// Assumes: Byte addresses on a 32-bit AHB-Lite bus, decoded on haddr[11:0]
// Notes: Definitions only
`ifndef IVS_MAP_SVH
`define IVS_MAP_SVH

`define IVS_ADDR_W 12
`define IVS_OFF_PRIORITY_SHADOW_REG 12'h000
`define IVS_OFF_STAT 12'h004
`define IVS_OFF_TBL_FIRST 12'h400
`define IVS_OFF_TBL_LAST 12'h7fc
`define IVS_TBL_IDX_HI 9
`define IVS_TBL_IDX_LO 2

`define IVS_PRIORITY_SHADOW_REG_RST 32'h0000_0000
`define IVS_PRIORITY_SHADOW_REG_SS_EN_BIT 0
`define IVS_SS_FIELD_W 4
`define IVS_SS_RSVD_BIT 3
`define IVS_STAT_RST 8'h00

`define IVS_VOFF_HI 17
`define IVS_VOFF_LO 1
`define IVS_VOFF_W 17

`define IVS_SRC_W 8
`define IVS_SRC_N 256
`define IVS_PRIO_W 3
`define IVS_SET_W 3
`define IVS_SET_DEFAULT 3'h0

`endif

// File: common/ivs_pkg.sv
// Purpose: Shared types of the vector/shadow block
// Assumes: Constants live in ivs_map.svh
// Notes: Types only
`include "ivs_map.svh"
package ivs_pkg;
	typedef logic [`IVS_SRC_W-1:0] ivs_src_t;
	typedef logic [`IVS_PRIO_W-1:0] ivs_prio_t;
	typedef logic [`IVS_SET_W-1:0] ivs_set_t;
	typedef logic [`IVS_VOFF_W-1:0] ivs_voff_t;
	typedef enum logic [2:0] {
		IVS_DP_IDLE,
		IVS_DP_WRITE,
		IVS_DP_REG_READ,
		IVS_DP_TBL_ISSUE,
		IVS_DP_TBL_CAPTURE,
		IVS_DP_TBL_DONE
	} ivs_dp_e;
endpackage

// File: rtl/ivs_offset_mem.sv
// Purpose: Per-source vector offset storage, one write and one read port
// Assumes: Single clock; read data registered one cycle after read enable
// Notes: Array is not reset; software programs every used offset
`timescale 1ns/1ps
`default_nettype none
`include "ivs_map.svh"
module ivs_offset_mem (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic we,
	input wire ivs_pkg::ivs_src_t waddr,
	input wire ivs_pkg::ivs_voff_t wdata,
	input wire logic re,
	input wire ivs_pkg::ivs_src_t raddr,
	output ivs_pkg::ivs_voff_t rdata_q
);
	import ivs_pkg::*;

	ivs_voff_t mem [`IVS_SRC_N];
	ivs_voff_t rdata_d;

	always_comb begin
		rdata_d = rdata_q;
		if (re) begin
			rdata_d = mem[raddr];
		end
	end

	always_ff @(posedge hclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end
endmodule
`default_nettype wire

// File: rtl/ivs_shadow_sel.sv
// Purpose: Pick the shadow register set for a priority level
// Assumes: Priority fields of 4 bits, priority x at bits 4x+3:4x, x = 1..7
// Notes: Reserved codes fall back to the default set
`timescale 1ns/1ps
`default_nettype none
`include "ivs_map.svh"
module ivs_shadow_sel (
	input wire logic [31:0] priority_shadow_reg,
	input wire ivs_pkg::ivs_prio_t prio,
	input wire logic single_vector,
	output ivs_pkg::ivs_set_t shadow_set,
	output logic shadow_use
);
	import ivs_pkg::*;

	function automatic ivs_set_t decode_field(input logic [`IVS_SS_FIELD_W-1:0] fld);
		decode_field = fld[`IVS_SS_RSVD_BIT] ? `IVS_SET_DEFAULT : fld[`IVS_SET_W-1:0];
	endfunction

	logic [`IVS_SS_FIELD_W-1:0] field;
	ivs_set_t set_from_prio;

	always_comb begin
		field = priority_shadow_reg[{prio, 2'b00} +: `IVS_SS_FIELD_W];
		set_from_prio = (prio == '0) ? `IVS_SET_DEFAULT : decode_field(field);
		if (single_vector) begin
			shadow_use = priority_shadow_reg[`IVS_PRIORITY_SHADOW_REG_SS_EN_BIT];
			shadow_set = shadow_use ? set_from_prio : `IVS_SET_DEFAULT;
		end else begin
			shadow_use = 1'b1;
			shadow_set = set_from_prio;
		end
	end
endmodule
`default_nettype wire

// File: rtl/ivs_top.sv
// Purpose: Interrupt vector offset table, shadow set selection and serviced-request status
// Assumes: AHB-Lite slave, single word transfers; core pulses irq_take when it services a request
// Notes: Table reads take two wait states, more while the core is using the table port
`timescale 1ns/1ps
`default_nettype none
`include "ivs_map.svh"
// Function
// - Per-source offset; vector equals base plus offset
// - Spacing set by per-source offsets, not fixed
// - Seven extra shadow sets, per-priority 4-bit select
// - Codes 0-7 pick set; 1xxx reserved, default 0
// - Bit 0 enables shadow set for single vector
// - Status bits 7:0 hold last serviced request
module ivs_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic irq_take,
	input wire ivs_pkg::ivs_src_t irq_num,
	input wire ivs_pkg::ivs_prio_t irq_prio,
	input wire logic single_vector_mode,
	input wire logic [31:0] exception_base,
	output logic vector_valid,
	output logic [31:0] vector_addr,
	output ivs_pkg::ivs_set_t shadow_set,
	output logic shadow_use,
	output ivs_pkg::ivs_src_t last_serviced_irq
);
	import ivs_pkg::*;

	function automatic logic [31:0] voff_word(input ivs_voff_t v);
		voff_word = {{(31 - `IVS_VOFF_HI){1'b0}}, v, 1'b0};
	endfunction

	function automatic ivs_src_t tbl_index(input logic [`IVS_ADDR_W-1:0] a);
		tbl_index = a[`IVS_TBL_IDX_HI:`IVS_TBL_IDX_LO];
	endfunction

	// Bus data phase
	ivs_dp_e dp_q, dp_d;
	logic [`IVS_ADDR_W-1:0] dp_addr_q, dp_addr_d;
	logic [31:0] hrdata_q, hrdata_d;
	// Registers
	logic [31:0] priority_shadow_reg_q, priority_shadow_reg_d;
	ivs_src_t stat_q, stat_d;
	// Service pipeline
	logic s1_q, s1_d;
	ivs_src_t s1_num_q, s1_num_d;
	logic [31:0] s1_base_q, s1_base_d;
	logic s2_q, s2_d;
	logic [31:0] vec_q, vec_d;
	ivs_set_t set_q, set_d;
	logic use_q, use_d;

	logic addr_ok;
	logic [`IVS_ADDR_W-1:0] a_addr;
	logic a_is_tbl;
	logic tbl_we;
	logic mem_re;
	ivs_src_t mem_raddr;
	ivs_voff_t mem_rdata;
	ivs_set_t sel_set;
	logic sel_use;

	assign a_addr = haddr[`IVS_ADDR_W-1:0];
	assign addr_ok = hsel && htrans[1] && hready;
	assign a_is_tbl = (a_addr >= `IVS_OFF_TBL_FIRST) && (a_addr <= `IVS_OFF_TBL_LAST);

	// Core lookups own the table port; bus reads wait
	assign mem_re = irq_take || (dp_q == IVS_DP_TBL_ISSUE);
	assign mem_raddr = irq_take ? irq_num : tbl_index(dp_addr_q);
	assign tbl_we = (dp_q == IVS_DP_WRITE) && (dp_addr_q >= `IVS_OFF_TBL_FIRST) &&
		(dp_addr_q <= `IVS_OFF_TBL_LAST);

	ivs_offset_mem u_mem (
		.hclk(hclk),
		.hresetn(hresetn),
		.we(tbl_we),
		.waddr(tbl_index(dp_addr_q)),
		.wdata(hwdata[`IVS_VOFF_HI:`IVS_VOFF_LO]),
		.re(mem_re),
		.raddr(mem_raddr),
		.rdata_q(mem_rdata)
	);

	ivs_shadow_sel u_sel (
		.priority_shadow_reg(priority_shadow_reg_q),
		.prio(irq_prio),
		.single_vector(single_vector_mode),
		.shadow_set(sel_set),
		.shadow_use(sel_use)
	);

	always_comb begin
		dp_d = dp_q;
		dp_addr_d = dp_addr_q;
		hrdata_d = hrdata_q;
		priority_shadow_reg_d = priority_shadow_reg_q;
		case (dp_q)
		IVS_DP_WRITE: begin
			if (dp_addr_q == `IVS_OFF_PRIORITY_SHADOW_REG) begin
				priority_shadow_reg_d = hwdata;
			end
			dp_d = IVS_DP_IDLE;
		end
		IVS_DP_TBL_ISSUE: begin
			if (!irq_take) begin
				dp_d = IVS_DP_TBL_CAPTURE;
			end
		end
		IVS_DP_TBL_CAPTURE: begin
			hrdata_d = voff_word(mem_rdata);
			dp_d = IVS_DP_TBL_DONE;
		end
		default: begin
			dp_d = IVS_DP_IDLE;
		end
		endcase
		if (hready) begin
			dp_d = IVS_DP_IDLE;
			if (addr_ok) begin
				dp_addr_d = a_addr;
				if (hwrite) begin
					dp_d = IVS_DP_WRITE;
				end else if (a_is_tbl) begin
					dp_d = IVS_DP_TBL_ISSUE;
				end else begin
					dp_d = IVS_DP_REG_READ;
					if (a_addr == `IVS_OFF_PRIORITY_SHADOW_REG) begin
						hrdata_d = priority_shadow_reg_q;
					end else if (a_addr == `IVS_OFF_STAT) begin
						hrdata_d = {{(32 - `IVS_SRC_W){1'b0}}, stat_q};
					end else begin
						hrdata_d = '0;
					end
				end
			end
		end
	end

	assign hreadyout = !((dp_q == IVS_DP_TBL_ISSUE) || (dp_q == IVS_DP_TBL_CAPTURE));
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_q <= IVS_DP_IDLE;
			dp_addr_q <= '0;
			hrdata_q <= '0;
			priority_shadow_reg_q <= `IVS_PRIORITY_SHADOW_REG_RST;
		end else begin
			dp_q <= dp_d;
			dp_addr_q <= dp_addr_d;
			hrdata_q <= hrdata_d;
			priority_shadow_reg_q <= priority_shadow_reg_d;
		end
	end

	// Service pipeline: lookup while presenting shadow set, then present vector
	always_comb begin
		s1_d = irq_take;
		s1_num_d = irq_take ? irq_num : s1_num_q;
		s1_base_d = irq_take ? exception_base : s1_base_q;
		set_d = irq_take ? sel_set : set_q;
		use_d = irq_take ? sel_use : use_q;
		s2_d = s1_q;
		vec_d = vec_q;
		stat_d = stat_q;
		if (s1_q) begin
			vec_d = s1_base_q + voff_word(mem_rdata);
			stat_d = s1_num_q;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_q <= 1'b0;
			s1_num_q <= '0;
			s1_base_q <= '0;
			s2_q <= 1'b0;
			vec_q <= '0;
			set_q <= `IVS_SET_DEFAULT;
			use_q <= 1'b0;
			stat_q <= `IVS_STAT_RST;
		end else begin
			s1_q <= s1_d;
			s1_num_q <= s1_num_d;
			s1_base_q <= s1_base_d;
			s2_q <= s2_d;
			vec_q <= vec_d;
			set_q <= set_d;
			use_q <= use_d;
			stat_q <= stat_d;
		end
	end

	assign vector_valid = s2_q;
	assign vector_addr = vec_q;
	assign shadow_set = set_q;
	assign shadow_use = use_q;
	assign last_serviced_irq = stat_q;

	// Checks
	default clocking ivs_cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence take_seq;
		irq_take && !single_vector_mode;
	endsequence

	a_vec_sum: assert property (s1_q |=> vector_valid && vector_addr ==
		$past(s1_base_q) + voff_word($past(mem_rdata)))
		else $error("vector address not base plus offset");

	a_vec_low_bit: assert property (vector_valid |->
		vector_addr[0] == $past(s1_base_q[0]))
		else $error("offset bit 0 leaked into vector");

	a_stat_last: assert property (irq_take |-> ##2 vector_valid &&
		last_serviced_irq == $past(irq_num, 2))
		else $error("status does not hold last serviced request");

	a_ss_multi: assert property (take_seq ##0 (irq_prio != '0) |-> ##1 shadow_use &&
		shadow_set == ($past(priority_shadow_reg_q[{irq_prio, 2'b00} + `IVS_SS_RSVD_BIT]) ? `IVS_SET_DEFAULT :
		$past(priority_shadow_reg_q[{irq_prio, 2'b00} +: `IVS_SET_W])))
		else $error("priority shadow set wrong");

	a_ss_rsvd: assert property (take_seq ##0 priority_shadow_reg_q[{irq_prio, 2'b00} + `IVS_SS_RSVD_BIT] |->
		##1 shadow_set == `IVS_SET_DEFAULT)
		else $error("reserved select did not fall back");

	a_ss_single: assert property (irq_take && single_vector_mode |->
		##1 shadow_use == $past(priority_shadow_reg_q[`IVS_PRIORITY_SHADOW_REG_SS_EN_BIT]) &&
		(shadow_use || shadow_set == `IVS_SET_DEFAULT))
		else $error("single vector shadow enable wrong");

	a_priority_shadow_reg_write: assert property (dp_q == IVS_DP_WRITE && dp_addr_q == `IVS_OFF_PRIORITY_SHADOW_REG |=>
		priority_shadow_reg_q == $past(hwdata))
		else $error("shadow select register not written");

	a_tbl_wait: assert property (addr_ok && !hwrite && a_is_tbl |=> !hreadyout [*2])
		else $error("table read answered too early");

	sequence bus_rd_seq;
		addr_ok && !hwrite;
	endsequence

	a_vec_origin: assert property (vector_valid |-> $past(irq_take, 2))
		else $error("vector presented without a take");

	a_vec_hold: assert property (!s1_q |=> $stable(vector_addr))
		else $error("vector address changed between results");

	a_stat_hold: assert property (!s1_q |=> $stable(last_serviced_irq))
		else $error("status changed without a serviced request");

	a_stat_read: assert property (bus_rd_seq ##0 (a_addr == `IVS_OFF_STAT) |=>
		hreadyout && hrdata == {{(32 - `IVS_SRC_W){1'b0}}, $past(stat_q)})
		else $error("status read data wrong");

	a_priority_shadow_reg_read: assert property (bus_rd_seq ##0 (a_addr == `IVS_OFF_PRIORITY_SHADOW_REG) |=>
		hreadyout && hrdata == $past(priority_shadow_reg_q))
		else $error("shadow select read data wrong");

	a_priority_shadow_reg_keep: assert property (!(dp_q == IVS_DP_WRITE && dp_addr_q == `IVS_OFF_PRIORITY_SHADOW_REG) |=>
		$stable(priority_shadow_reg_q))
		else $error("shadow select register changed unasked");

	a_tbl_read: assert property (dp_q == IVS_DP_TBL_CAPTURE |=>
		hreadyout && hrdata == voff_word($past(mem_rdata)))
		else $error("table read data wrong");

	a_tbl_stall: assert property (dp_q == IVS_DP_TBL_ISSUE && irq_take |=> dp_q == IVS_DP_TBL_ISSUE)
		else $error("table read not held behind a take");

	a_tbl_issue: assert property (dp_q == IVS_DP_TBL_ISSUE && !irq_take |=> dp_q == IVS_DP_TBL_CAPTURE)
		else $error("free table port not used");

	a_reg_ready: assert property (addr_ok && (hwrite || !a_is_tbl) |=> hreadyout)
		else $error("register access not answered at once");

	a_ss_prio0: assert property (take_seq ##0 (irq_prio == '0) |=>
		shadow_use && shadow_set == `IVS_SET_DEFAULT)
		else $error("priority zero left the default set");

	a_ss_single_off: assert property (irq_take && single_vector_mode && !priority_shadow_reg_q[`IVS_PRIORITY_SHADOW_REG_SS_EN_BIT] |=>
		!shadow_use && shadow_set == `IVS_SET_DEFAULT)
		else $error("single vector used a shadow set while disabled");

	a_ss_single_on: assert property (irq_take && single_vector_mode && priority_shadow_reg_q[`IVS_PRIORITY_SHADOW_REG_SS_EN_BIT] &&
		irq_prio != '0 && !priority_shadow_reg_q[{irq_prio, 2'b00} + `IVS_SS_RSVD_BIT] |=>
		shadow_use && shadow_set == $past(priority_shadow_reg_q[{irq_prio, 2'b00} +: `IVS_SET_W]))
		else $error("single vector shadow set wrong while enabled");

	a_ss_hold: assert property (!irq_take |=> $stable(shadow_set) && $stable(shadow_use))
		else $error("shadow selection changed without a take");
endmodule
`default_nettype wire

// File: tb/ivs_core_model.sv
// Purpose: Core side that takes vectored interrupts
// Assumes: One-cycle irq_take pulse, fields held with it
// Notes: Fields show inverted values after a take, zeros before the first take
`timescale 1ns/1ps
`default_nettype none
module ivs_core_model (
	input wire logic hclk,
	output logic irq_take,
	output ivs_pkg::ivs_src_t irq_num,
	output ivs_pkg::ivs_prio_t irq_prio,
	output logic single_vector_mode,
	output logic [31:0] exception_base
);
	import ivs_pkg::*;
	initial begin
		irq_take = 1'b0;
		irq_num = '0;
		irq_prio = '0;
		single_vector_mode = 1'b0;
		exception_base = 32'h0000_0000;
	end
	task automatic take(input ivs_src_t s, input ivs_prio_t p, input logic svm, input logic [31:0] b);
		@(posedge hclk);
		irq_take <= 1'b1;
		irq_num <= s;
		irq_prio <= p;
		single_vector_mode <= svm;
		exception_base <= b;
		@(posedge hclk);
		irq_take <= 1'b0;
		irq_num <= ~s;
		irq_prio <= ~p;
		single_vector_mode <= ~svm;
		exception_base <= ~b;
	endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Purpose: Self-checking bench for the vector/shadow block
// Assumes: AHB-Lite master tasks, core model drives service requests
// Notes: Expected values come from the model arrays below
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import ivs_pkg::*;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [1:0] htrans = 2'b00;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, vector_addr, rd, d, base, priority_shadow_reg_m;
	logic hreadyout, hresp, vector_valid, shadow_use, irq_take, single_vector_mode, euse;
	ivs_set_t shadow_set, eset;
	ivs_src_t irq_num, last_serviced_irq, src, last_m;
	ivs_prio_t irq_prio;
	logic [31:0] exception_base;
	logic [3:0] fld;
	logic [31:0] offm [256];
	int err_total = 0, checked = 0, seed = 77;
	always #12.5 hclk = ~hclk;
	ivs_core_model core (.hclk(hclk), .irq_take(irq_take), .irq_num(irq_num), .irq_prio(irq_prio),
		.single_vector_mode(single_vector_mode), .exception_base(exception_base));
	ivs_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .irq_take(irq_take), .irq_num(irq_num), .irq_prio(irq_prio),
		.single_vector_mode(single_vector_mode), .exception_base(exception_base),
		.vector_valid(vector_valid), .vector_addr(vector_addr), .shadow_set(shadow_set),
		.shadow_use(shadow_use), .last_serviced_irq(last_serviced_irq));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50) chk(32'h0000_0000, 32'h0000_0001);
	endtask
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rdv);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= wr;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_rdy();
		rdv = hrdata;
		chk({31'h0000_0000, hresp}, 32'h0000_0000);
	endtask
	task automatic serve(input ivs_src_t s, input ivs_prio_t p, input logic svm);
		base = $random(seed);
		fld = priority_shadow_reg_m[4*p +: 4];
		euse = svm ? priority_shadow_reg_m[0] : 1'b1;
		eset = (p == 3'h0 || fld[3] || !euse) ? 3'h0 : fld[2:0];
		core.take(s, p, svm, base);
		#1;
		chk({28'h000_0000, shadow_use, shadow_set}, {28'h000_0000, euse, eset});
		chk({31'h0000_0000, vector_valid}, 32'h0000_0000);
		@(posedge hclk);
		#1;
		chk({31'h0000_0000, vector_valid}, 32'h0000_0001);
		chk(vector_addr, base + offm[s]);
		chk({24'h00_0000, last_serviced_irq}, {24'h00_0000, s});
		last_m = s;
	endtask
	task automatic final_report();
		$display("counts: checked=%0d err_total=%0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (4000) @(posedge hclk);
		err_total++;
		final_report();
	end
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, 32'h0000_0000, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0000);
		bus(1'b0, 32'h0000_0004, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0000);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			src = (i == 0) ? 8'h00 : 8'(i * 36 + 3);
			d = $random(seed);
			offm[src] = d & 32'h0003_fffe;
			bus(1'b1, {22'h00_0000, src, 2'b00} + 32'h0000_0400, d, rd);
			bus(1'b0, {22'h00_0000, src, 2'b00} + 32'h0000_0400, 32'h0000_0000, rd);
			chk(rd, offm[src]);
		end
		$display("test offsets done");
		for (int c = 0; c < 3; c++) begin
			priority_shadow_reg_m = (c == 0) ? 32'h8765_4320 : (c == 1) ? 32'h0f1e_9071 : $random(seed);
			bus(1'b1, 32'h0000_0000, priority_shadow_reg_m, rd);
			bus(1'b0, 32'h0000_0000, 32'h0000_0000, rd);
			chk(rd, priority_shadow_reg_m);
			for (int p = 0; p < 8; p++) begin
				src = (p == 0) ? 8'h00 : 8'(p * 36 + 3);
				serve(src, 3'(p), 1'b0);
				serve(src, 3'(p), 1'b1);
			end
		end
		$display("test service done");
		bus(1'b1, 32'h0000_0004, 32'hffff_ffff, rd);
		bus(1'b0, 32'h0000_0004, 32'h0000_0000, rd);
		chk(rd, {24'h00_0000, last_m});
		bus(1'b1, 32'h0000_0008, 32'hffff_ffff, rd);
		bus(1'b0, 32'h0000_0008, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0000);
		$display("test status done");
		final_report();
	end
endmodule
`default_nettype wire
